// ===== modulation_mode_control.sv
`default_nettype none
module modulation_mode_control
  import modctl_pkg::*;
(
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic cmd_valid_i,
  input wire modctl_pkg::cmd_s cmd_i,
  input wire logic trig_i,
  input wire logic signed [11:0] ext_mod_i,
  output modctl_pkg::cfg_s cfg_o,
  output modctl_pkg::mode_e mode_o,
  output logic shift_keying_enable_o,
  output logic sweep_on_o,
  output logic burst_on_o,
  output logic ack_o,
  output logic reject_o,
  output logic hop_sel_o,
  output logic [47:0] out_freq_o,
  output logic signed [9:0] phase_shift_o,
  output logic [5:0] decim_step_o
);
  import modctl_pkg::*;

  cfg_s cfg_q, cfg_d;
  mode_e mode_q, mode_d;
  logic sweep_q, sweep_d, burst_q, burst_d, ack_q, ack_d, rej_q, rej_d, fsk_q, fsk_d;
  logic hop_q, hop_d;
  logic [47:0] freq_q, freq_d;
  logic signed [9:0] phase_q, phase_d;
  logic [5:0] decim_q, decim_d;
  logic trig_meta_q, trig_sync_q;
  logic int_wave;
  logic signed [21:0] prod;
  logic [17:0] len_round;

  // Trigger pin synchroniser; level sense is fixed, no polarity option exists
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      trig_meta_q <= 1'b0;
      trig_sync_q <= 1'b0;
    end
    else
    begin
      trig_meta_q <= trig_i;
      trig_sync_q <= trig_meta_q;
    end
  end

  shift_rate_gen u_rate (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .rate_i(cfg_q.shift_rate_setting),
    .wave_o(int_wave)
  );

  // Setting commands: all but the two source commands and burst are checked, then applied or refused as a whole
  always_comb
  begin
    logic ok;
    shape_e sh;
    mode_e m;
    ok = 1'b1;
    sh = shape_e'(cmd_i.val[2:0]);
    m = mode_e'(cmd_i.val[2:0]);
    cfg_d = cfg_q;
    mode_d = mode_q;
    sweep_d = sweep_q;
    burst_d = burst_q;
    if (cmd_valid_i)
    begin
      case (cmd_i.op)
        CMD_SHAPE:
        begin
          if (cmd_i.val[47:3] != 45'h0 || sh > SH_DC)
            ok = 1'b0;
          else if ((mode_q == MODE_FSK || sweep_q) && !carrier_ok(sh))
            ok = 1'b0;
          else if ((mode_q == MODE_PWM) != (sh == SH_PULSE) && mode_q != MODE_NONE)
            ok = 1'b0;
          else if (carrier_ok(sh) && (cfg_q.carrier > freq_max(sh) || cfg_q.hop_frequency_setting > freq_max(sh)))
            ok = 1'b0;
          else
            cfg_d.shape = sh;
        end
        CMD_CARRIER:
        begin
          if (cmd_i.val < FREQ_MIN || cmd_i.val > freq_max(cfg_q.shape))
            ok = 1'b0;
          else
            cfg_d.carrier = cmd_i.val;
        end
        CMD_HOP:
        begin
          if (cmd_i.val < FREQ_MIN || cmd_i.val > freq_max(cfg_q.shape))
            ok = 1'b0;
          else
            cfg_d.hop_frequency_setting = cmd_i.val;
        end
        CMD_RATE:
        begin
          if (cmd_i.val < {21'h0, RATE_MIN} || cmd_i.val > {21'h0, RATE_MAX})
            ok = 1'b0;
          else
            cfg_d.shift_rate_setting = cmd_i.val[26:0];
        end
        CMD_SHIFT_SRC:
          cfg_d.shift_source_select = src_e'(cmd_i.val[0]);
        CMD_PM_FREQ:
        begin
          if (cmd_i.val < {21'h0, PM_FREQ_MIN} || cmd_i.val > {21'h0, PM_FREQ_MAX})
            ok = 1'b0;
          else
            cfg_d.pm_freq = cmd_i.val[26:0];
        end
        CMD_PM_DEV:
        begin
          if (cmd_i.val > {39'h0, DEV_MAX})
            ok = 1'b0;
          else
            cfg_d.phase_deviation_setting = cmd_i.val[8:0];
        end
        CMD_PM_SRC:
          cfg_d.phase_mod_source_select = src_e'(cmd_i.val[0]);
        CMD_MSHAPE:
        begin
          if (cmd_i.val > {45'h0, MS_ARB})
            ok = 1'b0;
          else
            cfg_d.mshape = mshape_e'(cmd_i.val[2:0]);
        end
        CMD_PERIOD:
        begin
          if (cmd_i.val < {7'h0, PERIOD_MIN} || cmd_i.val > {7'h0, PERIOD_MAX})
            ok = 1'b0;
          else
            cfg_d.period = cmd_i.val[40:0];
        end
        CMD_ARB_LEN:
        begin
          if (cmd_i.val == 48'h0 || cmd_i.val[47:17] != 31'h0)
            ok = 1'b0;
          else
            cfg_d.arb_len = cmd_i.val[16:0];
        end
        CMD_MODE:
        begin
          if (cmd_i.val[47:3] != 45'h0 || m > MODE_PWM)
            ok = 1'b0;
          else if (m == MODE_PWM && cfg_q.shape != SH_PULSE)
            ok = 1'b0;
          else if (m != MODE_PWM && m != MODE_NONE && !carrier_ok(cfg_q.shape))
            ok = 1'b0;
          else
          begin
            mode_d = m;
            if (m != MODE_NONE)
            begin
              sweep_d = 1'b0;
              burst_d = 1'b0;
            end
          end
        end
        CMD_SWEEP:
        begin
          if (cmd_i.val[0] && !carrier_ok(cfg_q.shape))
            ok = 1'b0;
          else
          begin
            sweep_d = cmd_i.val[0];
            if (cmd_i.val[0])
            begin
              burst_d = 1'b0;
              mode_d = MODE_NONE;
            end
          end
        end
        CMD_BURST:
        begin
          burst_d = cmd_i.val[0];
          if (cmd_i.val[0])
          begin
            sweep_d = 1'b0;
            mode_d = MODE_NONE;
          end
        end
        default:
          ok = 1'b0;
      endcase
    end
    ack_d = cmd_valid_i && ok;
    rej_d = cmd_valid_i && !ok;
    fsk_d = (mode_d == MODE_FSK);
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      cfg_q <= CFG_RST;
      mode_q <= MODE_NONE;
      sweep_q <= 1'b0;
      burst_q <= 1'b0;
      ack_q <= 1'b0;
      rej_q <= 1'b0;
      fsk_q <= 1'b0;
    end
    else
    begin
      cfg_q <= cfg_d;
      mode_q <= mode_d;
      sweep_q <= sweep_d;
      burst_q <= burst_d;
      ack_q <= ack_d;
      rej_q <= rej_d;
      fsk_q <= fsk_d;
    end
  end

  // Output steering: keyed frequency, external phase shift, decimation step
  always_comb
  begin
    prod = 22'(signed'({1'b0, cfg_q.phase_deviation_setting})) * 22'(ext_mod_i);
    len_round = {1'b0, cfg_q.arb_len} + {1'b0, ARB_POINTS_MAX} - 18'h0_0001;
    hop_d = 1'b0;
    if (mode_q == MODE_FSK)
    begin
      // The programmed rate is simply not consulted on the external source
      if (cfg_q.shift_source_select == SRC_EXT)
        hop_d = trig_sync_q;
      else
        hop_d = int_wave;
    end
    freq_d = hop_d ? cfg_q.hop_frequency_setting : cfg_q.carrier;
    phase_d = 10'sh000;
    if (mode_q == MODE_PM && cfg_q.phase_mod_source_select == SRC_EXT)
    begin
      // Code 7FF is +5 V; pinned so full scale gives the whole deviation, not 2047/2048 of it
      if (ext_mod_i == signed'(ADC_FULL_POS))
        phase_d = signed'({1'b0, cfg_q.phase_deviation_setting});
      else
        phase_d = 10'(prod >>> ADC_SHIFT);
    end
    decim_d = 6'h01;
    if (cfg_q.mshape == MS_ARB && cfg_q.arb_len > ARB_POINTS_MAX)
      decim_d = 6'(len_round >> ARB_SHIFT);
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      hop_q <= 1'b0;
      freq_q <= CARRIER_RST;
      phase_q <= 10'sh000;
      decim_q <= 6'h01;
    end
    else
    begin
      hop_q <= hop_d;
      freq_q <= freq_d;
      phase_q <= phase_d;
      decim_q <= decim_d;
    end
  end

  assign cfg_o = cfg_q;
  assign mode_o = mode_q;
  assign shift_keying_enable_o = fsk_q;
  assign sweep_on_o = sweep_q;
  assign burst_on_o = burst_q;
  assign ack_o = ack_q;
  assign reject_o = rej_q;
  assign hop_sel_o = hop_q;
  assign out_freq_o = freq_q;
  assign phase_shift_o = phase_q;
  assign decim_step_o = decim_q;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (srst_i);

  keying_exclusive_a: assert property (mode_q == MODE_FSK |-> !sweep_q && !burst_q)
    else $error("shift keying active with sweep or burst");
  pwm_pulse_only_a: assert property (mode_q == MODE_PWM |-> cfg_q.shape == SH_PULSE && !sweep_q && !burst_q)
    else $error("pulse-width modulation outside pulse shape or with sweep/burst");
  keyed_carrier_shape_a: assert property (mode_q == MODE_FSK |-> carrier_ok(cfg_q.shape))
    else $error("keyed carrier has an illegal shape");
  carrier_bound_a: assert property (cfg_q.carrier <= freq_max(cfg_q.shape) || !carrier_ok(cfg_q.shape))
    else $error("carrier above shape limit");
  hop_bound_a: assert property (cfg_q.hop_frequency_setting <= freq_max(cfg_q.shape) || !carrier_ok(cfg_q.shape))
    else $error("hop frequency above shape limit");
  dev_range_a: assert property (cfg_q.phase_deviation_setting <= DEV_MAX)
    else $error("phase deviation above 360");
  rate_range_a: assert property (cfg_q.shift_rate_setting >= RATE_MIN && cfg_q.shift_rate_setting <= RATE_MAX)
    else $error("shift rate out of range");
  ext_trig_follow_a: assert property ($past(mode_q == MODE_FSK && cfg_q.shift_source_select == SRC_EXT) |->
                                      hop_sel_o == $past(trig_i, 3) && out_freq_o == (hop_sel_o ?
                                      $past(cfg_q.hop_frequency_setting) : $past(cfg_q.carrier)))
    else $error("external keying does not follow trigger");
  keying_takeover_a: assert property (cmd_valid_i && cmd_i.op == CMD_MODE && cmd_i.val == 48'(MODE_FSK) &&
                                      carrier_ok(cfg_q.shape) ##1 1'b1 |-> mode_q == MODE_FSK && ack_o && !sweep_q)
    else $error("enabling shift keying did not replace the previous mode");
  full_scale_a: assert property (mode_q == MODE_PM && cfg_q.phase_mod_source_select == SRC_EXT &&
                                 ext_mod_i == signed'(ADC_FULL_POS) |=>
                                 phase_shift_o == signed'({1'b0, $past(cfg_q.phase_deviation_setting)}))
    else $error("full positive input did not give full deviation");

  cover_ext_key_c: cover property (mode_q == MODE_FSK && cfg_q.shift_source_select == SRC_EXT ##1 hop_sel_o ##1 !hop_sel_o);
  cover_int_key_c: cover property (mode_q == MODE_FSK && cfg_q.shift_source_select == SRC_INT && hop_sel_o);
  cover_reject_c: cover property (reject_o);
  cover_pwm_c: cover property (mode_q == MODE_PWM);
endmodule
`default_nettype wire

// ===== modctl_pkg.sv
`default_nettype none
package modctl_pkg;
  // Clock and internal-rate arithmetic
  localparam longint unsigned CLK_HZ = 64'h0000_0000_05F5_E100;
  localparam longint unsigned MHZ_PER_HZ = 64'h0000_0000_0000_03E8;
  // One shift period is this many accumulator units (rate in mHz times clock cycles)
  localparam logic [37:0] ACC_MOD = 38'(CLK_HZ * MHZ_PER_HZ);
  localparam logic [37:0] ACC_HALF = 38'(CLK_HZ * MHZ_PER_HZ / 2);

  // Frequencies in uHz, rates in mHz, periods in ns
  localparam logic [47:0] FREQ_MIN = 48'h0000_0000_0001;
  localparam logic [47:0] FREQ_MAX_SINE = 48'd20_000_000_000_000;
  localparam logic [47:0] FREQ_MAX_RAMP = 48'd200_000_000_000;
  localparam logic [47:0] FREQ_MAX_ARB = 48'd6_000_000_000_000;
  localparam logic [47:0] CARRIER_RST = 48'd1_000_000_000;
  localparam logic [47:0] HOP_RST = 48'd100_000_000;
  localparam logic [26:0] RATE_MIN = 27'h000_0002;
  localparam logic [26:0] RATE_MAX = 27'd100_000_000;
  localparam logic [26:0] RATE_RST = 27'd10_000;
  localparam logic [26:0] PM_FREQ_MIN = 27'h000_0002;
  localparam logic [26:0] PM_FREQ_MAX = 27'd20_000_000;
  localparam logic [26:0] PM_FREQ_RST = 27'd10_000;
  localparam logic [8:0] DEV_MAX = 9'h168;
  localparam logic [8:0] DEV_RST = 9'h0B4;
  localparam logic [40:0] PERIOD_MIN = 41'h000_0000_00C8;
  localparam logic [40:0] PERIOD_MAX = 41'd2_000_000_000_000;
  localparam logic [40:0] PERIOD_RST = 41'h000_000F_4240;
  localparam logic [16:0] ARB_LEN_RST = 17'h0_1000;
  localparam logic [16:0] ARB_POINTS_MAX = 17'h0_1000;
  localparam int unsigned ARB_SHIFT = 12;
  localparam logic [11:0] ADC_FULL_POS = 12'h7FF;
  localparam int unsigned ADC_SHIFT = 11;

  typedef enum logic [2:0] {SH_SINE, SH_SQUARE, SH_RAMP, SH_ARB, SH_PULSE, SH_NOISE, SH_DC} shape_e;
  typedef enum logic [2:0] {MS_SINE, MS_SQUARE, MS_RAMP, MS_NRAMP, MS_TRI, MS_NOISE, MS_ARB} mshape_e;
  typedef enum logic [2:0] {MODE_NONE, MODE_AM, MODE_FM, MODE_PM, MODE_FSK, MODE_PWM} mode_e;
  typedef enum logic {SRC_INT, SRC_EXT} src_e;
  typedef enum logic [3:0] {
    CMD_SHAPE, CMD_CARRIER, CMD_HOP, CMD_RATE, CMD_SHIFT_SRC, CMD_PM_FREQ, CMD_PM_DEV,
    CMD_PM_SRC, CMD_MSHAPE, CMD_PERIOD, CMD_ARB_LEN, CMD_MODE, CMD_SWEEP, CMD_BURST
  } cmd_e;

  typedef struct packed {
    shape_e shape;
    logic [47:0] carrier;
    logic [47:0] hop_frequency_setting;
    logic [26:0] shift_rate_setting;
    src_e shift_source_select;
    logic [26:0] pm_freq;
    logic [8:0] phase_deviation_setting;
    src_e phase_mod_source_select;
    mshape_e mshape;
    logic [40:0] period;
    logic [16:0] arb_len;
  } cfg_s;

  typedef struct packed {
    cmd_e op;
    logic [47:0] val;
  } cmd_s;

  localparam cfg_s CFG_RST = '{SH_SINE, CARRIER_RST, HOP_RST, RATE_RST, SRC_INT, PM_FREQ_RST,
                               DEV_RST, SRC_INT, MS_SINE, PERIOD_RST, ARB_LEN_RST};

  // Shapes usable as a keyed or modulated carrier
  function automatic logic carrier_ok(shape_e s);
    return (s == SH_SINE) || (s == SH_SQUARE) || (s == SH_RAMP) || (s == SH_ARB);
  endfunction

  function automatic logic [47:0] freq_max(shape_e s);
    case (s)
      SH_RAMP: return FREQ_MAX_RAMP;
      SH_ARB: return FREQ_MAX_ARB;
      default: return FREQ_MAX_SINE;
    endcase
  endfunction
endpackage
`default_nettype wire

// ===== shift_rate_gen.sv
`default_nettype none
module shift_rate_gen
  import modctl_pkg::*;
(
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic [26:0] rate_i,
  output logic wave_o
);
  logic [37:0] acc_q, acc_d;
  logic [38:0] sum;
  logic wave_d, wave_q;

  // Modulo accumulator: exact average period of 1/rate, no division needed
  always_comb
  begin
    sum = {1'b0, acc_q} + {12'h000, rate_i};
    if (sum >= {1'b0, ACC_MOD})
    begin
      sum = sum - {1'b0, ACC_MOD};
    end
    acc_d = sum[37:0];
    wave_d = (acc_d >= ACC_HALF);
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      acc_q <= 38'h0;
      wave_q <= 1'b0;
    end
    else
    begin
      acc_q <= acc_d;
      wave_q <= wave_d;
    end
  end

  assign wave_o = wave_q;
endmodule
`default_nettype wire

// ===== trig_source.sv
`default_nettype none
module trig_source (
  input wire logic mclk_i,
  input wire logic want_i,
  output logic trig_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Shortest level the far side may hold: half of a 100 kHz toggle period
  localparam int MIN_HOLD = 500;
  int held = MIN_HOLD;
  initial trig_o = 1'b0;
  // A requested level waits until the old one has stood long enough
  always @(posedge mclk_i)
  begin
    if (want_i !== trig_o && held >= MIN_HOLD)
    begin
      trig_o <= want_i;
      held <= 0;
    end
    else if (held < MIN_HOLD)
      held <= held + 1;
  end
endmodule
`default_nettype wire

// ===== modulation_mode_control_bench.sv
`default_nettype none
module modulation_mode_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import modctl_pkg::*;
  logic mclk_i = 1'b0;
  logic srst_i = 1'b1;
  logic cmd_valid_i = 1'b0;
  logic want = 1'b0;
  logic trig;
  cmd_s cmd_i = '0;
  logic signed [11:0] ext_mod_i = '0;
  cfg_s cfg_o;
  mode_e mode_o;
  logic fsk_o, sweep_o, burst_o, ack_o, reject_o, hop_o;
  logic [47:0] freq_o;
  logic signed [9:0] phase_o;
  logic [5:0] decim_o;
  int bad_count = 0;
  int checked = 0;
  longint m_shp, m_car, m_hop, m_rate, m_ss, m_pmf, m_dev, m_ps, m_msh, m_per, m_arb, m_mode, m_sw, m_bu;
  // Op/value pairs: mode exclusivity first, then range edges
  longint seq[$] = '{12, 1, 11, 4, 13, 1, 11, 4, 11, 1, 11, 4, 0, 5, 0, 4, 0, 6, 11, 0, 11, 5, 0, 4, 11, 1,
    11, 5, 12, 1, 13, 1, 11, 5, 0, 0, 11, 0, 0, 0, 12, 1, 0, 4, 12, 0, 0, 5, 11, 4, 11, 2, 0, 0, 14, 0,
    15, 0, 11, 7, 8, 7, 3, 1, 3, 2, 3, 64'h5F5_E100, 3, 64'h5F5_E101, 5, 1, 5, 64'h131_2D00,
    5, 64'h131_2D01, 6, 64'h168, 6, 64'h169, 9, 64'hC7, 9, 64'hC8, 9, 64'h1D1_A94A_2000,
    9, 64'h1D1_A94A_2001, 10, 0, 10, 64'h1_FFFF, 10, 64'h2_0000, 1, 0, 2, 0};

  always #5 mclk_i = ~mclk_i;

  modulation_mode_control i_dut (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .cmd_valid_i(cmd_valid_i),
    .cmd_i(cmd_i),
    .trig_i(trig),
    .ext_mod_i(ext_mod_i),
    .cfg_o(cfg_o),
    .mode_o(mode_o),
    .shift_keying_enable_o(fsk_o),
    .sweep_on_o(sweep_o),
    .burst_on_o(burst_o),
    .ack_o(ack_o),
    .reject_o(reject_o),
    .hop_sel_o(hop_o),
    .out_freq_o(freq_o),
    .phase_shift_o(phase_o),
    .decim_step_o(decim_o)
  );

  trig_source i_trig (
    .mclk_i(mclk_i),
    .want_i(want),
    .trig_o(trig)
  );

  task automatic chk(input string nm, input logic [255:0] seen, input logic [255:0] exp);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic end_of_test();
    if (bad_count == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic tick();
    @(posedge mclk_i);
    #1;
  endtask

  function automatic longint lim(longint s);
    if (s == 2)
      return FREQ_MAX_RAMP;
    if (s == 3)
      return FREQ_MAX_ARB;
    return FREQ_MAX_SINE;
  endfunction

  task automatic model(input longint op, input longint v, output bit ok);
    longint e;
    e = v % 8;
    case (op)
      0: ok = e < 7 && !(e > 3 && (m_mode == 4 || m_sw)) && !(e != 4 && m_mode == 5)
          && !(e == 4 && m_mode != 0 && m_mode != 5) && lim(e) >= m_car && lim(e) >= m_hop;
      1, 2: ok = v > 0 && v <= lim(m_shp);
      3: ok = v > 1 && v <= 64'h5F5_E100;
      5: ok = v > 1 && v <= 64'h131_2D00;
      6: ok = v <= 64'h168;
      8: ok = e < 7;
      9: ok = v >= 64'hC8 && v <= 64'h1D1_A94A_2000;
      10: ok = v > 0 && v < 64'h2_0000;
      11: ok = e < 6 && (e == 5 ? m_shp == 4 : e == 0 || m_shp < 4);
      12: ok = !(v % 2 && m_shp > 3);
      4, 7, 13: ok = 1'b1;
      default: ok = 1'b0;
    endcase
    if (ok)
    begin
      case (op)
        0: m_shp = e;
        1: m_car = v;
        2: m_hop = v;
        3: m_rate = v;
        4: m_ss = v % 2;
        5: m_pmf = v;
        6: m_dev = v;
        7: m_ps = v % 2;
        8: m_msh = e;
        9: m_per = v;
        10: m_arb = v;
        11: m_mode = e;
        12: m_sw = v % 2;
        13: m_bu = v % 2;
        default: ;
      endcase
      // Any mode, sweep or burst switched on drops the other two
      if ((op == 11 && e != 0) || (op == 12 && m_sw) || (op == 13 && m_bu))
      begin
        m_sw = m_sw && op == 12;
        m_bu = m_bu && op == 13;
        m_mode = op == 11 ? e : 0;
      end
    end
  endtask

  task automatic state();
    chk("cfg", cfg_o, cfg_s'{shape_e'(m_shp[2:0]), m_car[47:0], m_hop[47:0], m_rate[26:0], src_e'(m_ss[0]),
      m_pmf[26:0], m_dev[8:0], src_e'(m_ps[0]), mshape_e'(m_msh[2:0]), m_per[40:0], m_arb[16:0]});
    chk("mode", mode_o, m_mode[2:0]);
    chk("keying", fsk_o, m_mode == 4);
    chk("sweep_burst", {sweep_o, burst_o}, {m_sw[0], m_bu[0]});
  endtask

  task automatic send(input longint op, input longint v);
    bit ok;
    @(posedge mclk_i);
    cmd_i <= '{cmd_e'(op[3:0]), v[47:0]};
    cmd_valid_i <= 1'b1;
    @(posedge mclk_i);
    cmd_valid_i <= 1'b0;
    #1;
    model(op, v, ok);
    chk("answer", {ack_o, reject_o}, {ok, !ok});
    state();
  endtask

  task automatic do_reset();
    @(posedge mclk_i);
    srst_i <= 1'b1;
    repeat (10) @(posedge mclk_i);
    srst_i <= 1'b0;
    #1;
    m_shp = 0;
    m_car = 64'h3B9A_CA00;
    m_hop = 64'h5F5_E100;
    m_rate = 64'h2710;
    m_ss = 0;
    m_pmf = 64'h2710;
    m_dev = 64'hB4;
    m_ps = 0;
    m_msh = 0;
    m_per = 64'hF_4240;
    m_arb = 64'h1000;
    m_mode = 0;
    m_sw = 0;
    m_bu = 0;
    state();
    chk("idle", {hop_o, freq_o, phase_o, decim_o}, {1'b0, 48'h3B9A_CA00, 10'h000, 6'h01});
  endtask

  initial
  begin
    longint op, v;
    int n, hi, rise, err, p;
    logic prev;
    int codes[$] = '{2047, 1024, 0, -2048, 1, -1};
    void'($urandom(50));
    do_reset();
    foreach (seq[i])
      if (i % 2 == 0)
        send(seq[i], seq[i + 1]);
    for (int s = 0; s < 4; s++)
    begin
      send(1, 1);
      send(2, 1);
      send(0, s);
      for (int k = 1; k < 3; k++)
        for (int d = 1; d >= 0; d--)
          send(k, lim(s) + d);
    end
    send(1, $urandom_range(1, 1000000));
    send(2, $urandom_range(1000001, 2000000));
    send(4, 1);
    send(11, 4);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge mclk_i);
      want <= !want;
      #1;
      for (n = 0; trig !== want && n < 1000; n++)
        @(posedge mclk_i);
      chk("trig_wait", n < 1000, 1);
      repeat (4) tick();
      chk("hop_sel", hop_o, want);
      chk("out_freq", freq_o, want ? m_hop[47:0] : m_car[47:0]);
      send(3, $urandom_range(2, 100000000));
      repeat (300) tick();
      chk("hop_hold", hop_o, want);
    end
    send(4, 0);
    send(3, 64'h5F5_E100);
    for (n = 0; hop_o !== 1'b0 && n < 2000; n++)
      tick();
    chk("key_low_wait", n < 2000, 1);
    for (n = 0; hop_o !== 1'b1 && n < 2000; n++)
      tick();
    chk("key_high_wait", n < 2000, 1);
    hi = 0;
    rise = 0;
    err = 0;
    prev = 1'b1;
    repeat (3500)
    begin
      tick();
      hi += hop_o;
      rise += hop_o && !prev;
      prev = hop_o;
      err += freq_o !== (hop_o ? m_hop[47:0] : m_car[47:0]);
    end
    chk("rises", rise, 3);
    chk("duty", hi > 1993 && hi < 2007, 1);
    chk("follow", err, 0);
    send(7, 1);
    send(11, 3);
    codes.push_back($urandom_range(0, 4095) - 2048);
    for (int d = 0; d < 3; d++)
    begin
      send(6, d * 180);
      foreach (codes[c])
      begin
        @(posedge mclk_i);
        ext_mod_i <= codes[c][11:0];
        tick();
        tick();
        p = codes[c] == 2047 ? d * 180 : (d * 180 * codes[c]) >>> 11;
        chk("phase", {phase_o}, {p[9:0]});
      end
    end
    send(7, 0);
    tick();
    chk("phase_int", {phase_o}, 10'h000);
    send(8, 6);
    foreach (codes[c])
    begin
      n = c == 0 ? 1 : 4096 * c + c % 2;
      send(10, n);
      tick();
      chk("decim", decim_o, n > 4096 ? (n + 4095) / 4096 : 1);
    end
    send(10, 64'h1_FFFF);
    tick();
    chk("decim_max", decim_o, 32);
    repeat (200)
    begin
      op = $urandom_range(0, 15);
      v = longint'($urandom_range(0, 400000000)) << $urandom_range(0, 15);
      if (op inside {0, 4, 7, 8, 11, 12, 13})
        v = $urandom_range(0, 7);
      send(op, v);
    end
    do_reset();
    end_of_test();
  end

  initial
  begin
    #700us;
    bad_count++;
    end_of_test();
  end
endmodule
`default_nettype wire
